// ### rtl/scvb_var_bank.v
// Communication variable bank of the servo drive.
//
// Operation
// - Ready bit zero follows bus-ready state.
// - Bits 12-13 encode not-ready/ready/running/fault.
// - Output functions 1-16 map to bits 0-15.
// - Brake bit invalid without brake assignment.
// - Functions 17-20 in low bits, rest reserved.
// - Pulse count shown for pulse or handwheel source.
// - Pulse count ignores control mode and run state.
// - Virtual input n+1 follows bit n.
// - Physical output n+1 follows bit n.
// - Comm speed reference, clamped to 6000.000 RPM.
// - Speed reference 32 bits, written only here.
// - Comm torque reference, clamped to 100.000 percent.
// - Full-scale torque equals rated motor torque.
// - Torque reference 32 bits, written only here.
`timescale 1ns/1ps
`include "scvb_defs.vh"

module scvb_var_bank #(
    parameter CTRL_PERIOD_CYC = `SCVB_CTRL_PERIOD_NS / `SCVB_CLK_PERIOD_NS,
    parameter CNT_W           = 16
) (
    input  wire        sys_clk,
    input  wire        srst,
    // Communication link parameter access.
    input  wire        par_req,
    input  wire        par_wr,
    input  wire [15:0] par_addr,
    input  wire [15:0] par_wdata,
    output reg  [15:0] par_rdata_r,
    output reg         par_ack_r,
    output reg         par_err_r,
    // Drive status from the control core.
    input  wire        bus_ready,
    input  wire        servo_on,
    input  wire        fault_class12,
    input  wire [19:0] out_func_active,
    input  wire        brake_assigned,
    input  wire        pos_source_pulse,
    input  wire        handwheel_active,
    input  wire        speed_mode_comm,
    input  wire        torque_mode_comm,
    input  wire        pulse_pin,
    // Values set over the link.
    output reg  [15:0] virtual_input_r,
    output reg  [15:0] out_level_r,
    output reg  [31:0] speed_cmd_r,
    output reg         speed_cmd_valid_r,
    output reg  [31:0] torque_cmd_r,
    output reg         torque_cmd_valid_r,
    output reg         period_tick_r
);

    // ======================================================================
    // Control period divider.
    // ======================================================================
    // The divider is 16 bits wide, so the last count is cut to that on
    // purpose; periods longer than 65536 cycles need a wider divider.
    localparam [31:0] PERIOD_LAST_W = CTRL_PERIOD_CYC - 1;
    localparam [15:0] PERIOD_LAST   = PERIOD_LAST_W[15:0];

    reg [15:0]      div_r;       // Cycle count within the control period.
    wire [CNT_W-1:0] pulse_cnt;  // Published per-period pulse count.

    // A one-cycle enable at the control period rate.
    always @(posedge sys_clk) begin
        if (srst) begin
            div_r         <= 16'h0000;
            period_tick_r <= 1'b0;
        end else if (div_r == PERIOD_LAST) begin
            div_r         <= 16'h0000;
            period_tick_r <= 1'b1;
        end else begin
            div_r         <= div_r + 16'h0001;
            period_tick_r <= 1'b0;
        end
    end

    // Pulse sampling runs unconditionally.
    scvb_pulse_sampler #(
        .CNT_W       (CNT_W)
    ) u_sampler (
        .sys_clk     (sys_clk),
        .srst        (srst),
        .pulse_pin   (pulse_pin),
        .period_tick (period_tick_r),
        .count_r     (pulse_cnt)
    );

    // ======================================================================
    // Status words.
    // ======================================================================
    reg [1:0]  run_state;   // Run-state code.
    reg [15:0] state_word;  // Servo-state word.
    reg [15:0] fn_low;      // Output functions 1 to 16.
    reg [15:0] fn_high;     // Output functions 17 to 20.

    // Fault outranks running, which outranks plain readiness.
    always @* begin
        if (fault_class12) begin
            run_state = `SCVB_RUN_FAULT;
        end else if (bus_ready && servo_on) begin
            run_state = `SCVB_RUN_RUNNING;
        end else if (bus_ready) begin
            run_state = `SCVB_RUN_READY;
        end else begin
            run_state = `SCVB_RUN_NOT_READY;
        end
    end

    // Words are assembled with reserved bits held at zero.
    always @* begin
        state_word = `SCVB_WORD_RESET;
        state_word[`SCVB_BIT_READY] = bus_ready;
        state_word[`SCVB_RUN_MSB:`SCVB_RUN_LSB] = run_state;
        fn_low = out_func_active[15:0];
        // An unassigned brake function carries no meaning, so it reads
        // zero rather than stale internal state.
        if (!brake_assigned) begin
            fn_low[`SCVB_BIT_BRAKE] = 1'b0;
        end
        fn_high = `SCVB_WORD_RESET;
        fn_high[`SCVB_OUTFN_HIGH_W-1:0] = out_func_active[19:16];
    end

    // ======================================================================
    // Address decoding.
    // ======================================================================
    // True for any address that this bank answers to.
    function mapped;
        input [15:0] a;
        begin
            case (a)
                `SCVB_ADDR_SERVO_STATE, `SCVB_ADDR_OUTFN_LOW,
                `SCVB_ADDR_OUTFN_HIGH, `SCVB_ADDR_PULSE_COUNT,
                `SCVB_ADDR_VIN_LEVELS, `SCVB_ADDR_OUT_LEVELS,
                `SCVB_ADDR_SPEED_LO, `SCVB_ADDR_SPEED_HI,
                `SCVB_ADDR_TORQUE_LO, `SCVB_ADDR_TORQUE_HI: mapped = 1'b1;
                default: mapped = 1'b0;
            endcase
        end
    endfunction

    // Saturates a signed reference to a symmetric limit.
    function [31:0] clamp;
        input [31:0] v;
        input [31:0] hi;
        input [31:0] lo;
        begin
            if ($signed(v) > $signed(hi)) begin
                clamp = hi;
            end else if ($signed(v) < $signed(lo)) begin
                clamp = lo;
            end else begin
                clamp = v;
            end
        end
    endfunction

    // ======================================================================
    // Writable storage and read mux.
    // ======================================================================
    reg [31:0] speed_raw_r;   // Speed reference as written.
    reg [31:0] torque_raw_r;  // Torque reference as written.
    reg [15:0] rd_mux;        // Read data selected by address.

    // Each access is answered one cycle after it is presented.
    always @* begin
        case (par_addr)
            `SCVB_ADDR_SERVO_STATE: rd_mux = state_word;
            `SCVB_ADDR_OUTFN_LOW:   rd_mux = fn_low;
            `SCVB_ADDR_OUTFN_HIGH:  rd_mux = fn_high;
            // Shown only while the pulse input or the handwheel feeds position.
            `SCVB_ADDR_PULSE_COUNT: rd_mux = (pos_source_pulse ||
                                              handwheel_active) ?
                                             pulse_cnt : `SCVB_WORD_RESET;
            `SCVB_ADDR_VIN_LEVELS:  rd_mux = virtual_input_r;
            `SCVB_ADDR_OUT_LEVELS:  rd_mux = out_level_r;
            `SCVB_ADDR_SPEED_LO:    rd_mux = speed_raw_r[15:0];
            `SCVB_ADDR_SPEED_HI:    rd_mux = speed_raw_r[31:16];
            `SCVB_ADDR_TORQUE_LO:   rd_mux = torque_raw_r[15:0];
            `SCVB_ADDR_TORQUE_HI:   rd_mux = torque_raw_r[31:16];
            default:                rd_mux = `SCVB_WORD_RESET;
        endcase
    end

    // Link access: writes to status words fall through untouched.
    always @(posedge sys_clk) begin
        if (srst) begin
            par_ack_r       <= 1'b0;
            par_err_r       <= 1'b0;
            par_rdata_r     <= `SCVB_WORD_RESET;
            virtual_input_r <= `SCVB_WORD_RESET;
            out_level_r     <= `SCVB_WORD_RESET;
            speed_raw_r     <= `SCVB_REF_RESET;
            torque_raw_r    <= `SCVB_REF_RESET;
        end else begin
            par_ack_r   <= par_req;
            par_err_r   <= par_req && !mapped(par_addr);
            par_rdata_r <= (par_req && !par_wr) ? rd_mux
                                                : `SCVB_WORD_RESET;
            if (par_req && par_wr) begin
                case (par_addr)
                    // Bit n sets virtual input n+1.
                    `SCVB_ADDR_VIN_LEVELS: virtual_input_r <= par_wdata;
                    // Bit n sets output n+1.
                    `SCVB_ADDR_OUT_LEVELS: out_level_r <= par_wdata;
                    // Only the link can reach these halves.
                    `SCVB_ADDR_SPEED_LO:  speed_raw_r[15:0] <= par_wdata;
                    `SCVB_ADDR_SPEED_HI:  speed_raw_r[31:16] <= par_wdata;
                    // Same for the torque reference.
                    `SCVB_ADDR_TORQUE_LO: torque_raw_r[15:0] <= par_wdata;
                    `SCVB_ADDR_TORQUE_HI: torque_raw_r[31:16] <= par_wdata;
                    // Status words and unmapped addresses ignore writes.
                    default: ;
                endcase
            end
        end
    end

    // ======================================================================
    // Applied references.
    // ======================================================================
    // The clamped value follows the stored one the next cycle, so a write
    // acts at once. Halves land separately; hosts that care about a torn
    // value should write the high half last.
    // Full scale 100000 counts means rated motor torque.
    always @(posedge sys_clk) begin
        if (srst) begin
            speed_cmd_r        <= `SCVB_REF_RESET;
            speed_cmd_valid_r  <= 1'b0;
            torque_cmd_r       <= `SCVB_REF_RESET;
            torque_cmd_valid_r <= 1'b0;
        end else begin
            speed_cmd_r <= clamp(speed_raw_r, `SCVB_SPEED_MAX,
                                 `SCVB_SPEED_MIN);
            speed_cmd_valid_r <= speed_mode_comm;
            torque_cmd_r <= clamp(torque_raw_r, `SCVB_TORQUE_MAX,
                                  `SCVB_TORQUE_MIN);
            torque_cmd_valid_r <= torque_mode_comm;
        end
    end

endmodule // scvb_var_bank

// ### rtl/scvb_defs.vh
// Constants for the servo communication variable bank.
`ifndef SCVB_DEFS_VH
`define SCVB_DEFS_VH

// ==========================================================================
// Parameter addresses: group in the high byte, index in the low byte.
// ==========================================================================
`define SCVB_ADDR_SERVO_STATE    16'h3000
`define SCVB_ADDR_OUTFN_LOW      16'h3001
`define SCVB_ADDR_OUTFN_HIGH     16'h3002
`define SCVB_ADDR_PULSE_COUNT    16'h3003
`define SCVB_ADDR_VIN_LEVELS     16'h3100
`define SCVB_ADDR_OUT_LEVELS     16'h3104
`define SCVB_ADDR_SPEED_LO       16'h3109
`define SCVB_ADDR_SPEED_HI       16'h310a
`define SCVB_ADDR_TORQUE_LO      16'h310b
`define SCVB_ADDR_TORQUE_HI      16'h310c

// ==========================================================================
// Field positions and codes.
// ==========================================================================
`define SCVB_BIT_READY           0
`define SCVB_RUN_LSB             12
`define SCVB_RUN_MSB             13
`define SCVB_RUN_NOT_READY       2'h0
`define SCVB_RUN_READY           2'h1
`define SCVB_RUN_RUNNING         2'h2
`define SCVB_RUN_FAULT           2'h3
`define SCVB_BIT_BRAKE           8
`define SCVB_OUTFN_HIGH_W        4

// ==========================================================================
// Limits and reset values of the references.
// ==========================================================================
`define SCVB_SPEED_MAX           32'sd6000000
`define SCVB_SPEED_MIN           -32'sd6000000
`define SCVB_TORQUE_MAX          32'sd100000
`define SCVB_TORQUE_MIN          -32'sd100000
`define SCVB_REF_RESET           32'h0000_0000
`define SCVB_WORD_RESET          16'h0000

// ==========================================================================
// Timing.
// ==========================================================================
`define SCVB_CLK_PERIOD_NS       40
`define SCVB_CTRL_PERIOD_NS      62500

`endif

// ### rtl/scvb_pulse_sampler.v
// Pulse input sampler counting edges over one control period.
`timescale 1ns/1ps
`include "scvb_defs.vh"

module scvb_pulse_sampler #(
    parameter CNT_W = 16  // Width of the per-period pulse count.
) (
    input  wire             sys_clk,
    input  wire             srst,
    input  wire             pulse_pin,
    input  wire             period_tick,
    output reg  [CNT_W-1:0] count_r
);

    // ======================================================================
    // Input synchroniser.
    // ======================================================================
    reg             s1_r;     // First stage, read only by the second.
    reg             s2_r;     // Second stage.
    reg             s3_r;     // Third stage.
    reg             level_r;  // Accepted pin level.
    reg [CNT_W-1:0] acc_r;    // Running count within the period.

    // Three flops; a new level is accepted when stages two and three agree.
    always @(posedge sys_clk) begin
        if (srst) begin
            s1_r    <= 1'b0;
            s2_r    <= 1'b0;
            s3_r    <= 1'b0;
            level_r <= 1'b0;
        end else begin
            s1_r <= pulse_pin;
            s2_r <= s1_r;
            s3_r <= s2_r;
            if (s2_r == s3_r) begin
                level_r <= s3_r;
            end
        end
    end

    // ======================================================================
    // Counting.
    // ======================================================================
    // Rising edges are counted regardless of drive mode or run state, so
    // the count never depends on anything but the pin.
    wire rise = (s2_r == s3_r) && s3_r && !level_r;

    // At each period tick the sum is published and the count restarts,
    // the edge of that same cycle opening the new period.
    always @(posedge sys_clk) begin
        if (srst) begin
            acc_r   <= {CNT_W{1'b0}};
            count_r <= {CNT_W{1'b0}};
        end else if (period_tick) begin
            count_r <= acc_r;
            acc_r   <= {{(CNT_W-1){1'b0}}, rise};
        end else if (rise) begin
            acc_r <= acc_r + {{(CNT_W-1){1'b0}}, 1'b1};
        end
    end

endmodule // scvb_pulse_sampler

// ### dv/scvb_var_bank_asserts.sv
// Concurrent checks on the ports of the communication variable bank.
`timescale 1ns/1ps
module scvb_var_bank_asserts (
    input logic        sys_clk,
    input logic        srst,
    input logic        par_req,
    input logic        par_wr,
    input logic [15:0] par_addr,
    input logic [15:0] par_wdata,
    input logic [15:0] par_rdata_r,
    input logic        par_ack_r,
    input logic        bus_ready,
    input logic        servo_on,
    input logic        fault_class12,
    input logic [19:0] out_func_active,
    input logic        brake_assigned,
    input logic        pos_source_pulse,
    input logic        handwheel_active,
    input logic        speed_mode_comm,
    input logic [15:0] virtual_input_r,
    input logic [15:0] out_level_r,
    input logic [31:0] speed_cmd_r,
    input logic        speed_cmd_valid_r,
    input logic [31:0] torque_cmd_r,
    input logic        period_tick_r
);
    // ====================
    // All checks sample on the system clock and sleep during reset.
    default clocking @(posedge sys_clk); endclocking
    default disable iff (srst);
    wire rd = par_req && !par_wr; // A read taken at this edge.
    wire wr = par_req && par_wr;  // A write taken at this edge.

    AST_ACK: assert property (par_req |=> par_ack_r)
        else $error("request not answered next cycle");
    AST_READY: assert property (rd && par_addr == 16'h3000 |=>
        par_rdata_r[0] == $past(bus_ready))
        else $error("ready bit wrong");
    AST_RUN: assert property (rd && par_addr == 16'h3000 |=>
        par_rdata_r[13:12] == ($past(fault_class12) ? 2'h3 :
        ($past(bus_ready) && $past(servo_on)) ? 2'h2 :
        {1'b0, $past(bus_ready)}))
        else $error("run state wrong");
    AST_RSVD: assert property (rd && par_addr == 16'h3000 |=>
        par_rdata_r[11:1] == 11'h000 && par_rdata_r[15:14] == 2'h0)
        else $error("reserved state bits set");
    AST_OUTFN_LOW: assert property (rd && par_addr == 16'h3001 |=>
        par_rdata_r == ($past(out_func_active[15:0]) &
        {7'h7f, $past(brake_assigned), 8'hff}))
        else $error("output function low word wrong");
    AST_OUTFN_HIGH: assert property (rd && par_addr == 16'h3002 |=>
        par_rdata_r == {12'h000, $past(out_func_active[19:16])})
        else $error("output function high word wrong");
    AST_PULSE_OFF: assert property (rd && par_addr == 16'h3003 &&
        !pos_source_pulse && !handwheel_active |=>
        par_rdata_r == 16'h0000)
        else $error("pulse count shown without pulse source");
    AST_VIN: assert property (wr && par_addr == 16'h3100 |=>
        virtual_input_r == $past(par_wdata))
        else $error("virtual inputs not written");
    AST_OUT: assert property (wr && par_addr == 16'h3104 |=>
        out_level_r == $past(par_wdata))
        else $error("output levels not written");
    AST_RO_WR: assert property (wr && par_addr[15:8] == 8'h30 |=>
        $stable(virtual_input_r) && $stable(out_level_r))
        else $error("status write disturbed writable words");
    AST_LIMITS: assert property ($signed(speed_cmd_r) <= 6000000 &&
        $signed(speed_cmd_r) >= -6000000 && $signed(torque_cmd_r) <= 100000
        && $signed(torque_cmd_r) >= -100000)
        else $error("reference outside its limit");
    AST_VALID: assert property (!$past(srst) |->
        speed_cmd_valid_r == $past(speed_mode_comm))
        else $error("speed valid does not follow mode");
    AST_TICK: assert property (period_tick_r |=> (!period_tick_r)[*8])
        else $error("control period tick too close");
endmodule // scvb_var_bank_asserts

bind scvb_var_bank scvb_var_bank_asserts u_chk (
    .sys_clk(sys_clk), .srst(srst), .par_req(par_req), .par_wr(par_wr),
    .par_addr(par_addr), .par_wdata(par_wdata), .par_rdata_r(par_rdata_r),
    .par_ack_r(par_ack_r), .bus_ready(bus_ready), .servo_on(servo_on),
    .fault_class12(fault_class12), .out_func_active(out_func_active),
    .brake_assigned(brake_assigned), .pos_source_pulse(pos_source_pulse),
    .handwheel_active(handwheel_active), .speed_mode_comm(speed_mode_comm),
    .virtual_input_r(virtual_input_r), .out_level_r(out_level_r),
    .speed_cmd_r(speed_cmd_r), .speed_cmd_valid_r(speed_cmd_valid_r),
    .torque_cmd_r(torque_cmd_r), .period_tick_r(period_tick_r));

// ### dv/scvb_host_model.sv
// Host controller model issuing parameter accesses over the link.
`timescale 1ns/1ps
module scvb_host_model (
    input  logic        sys_clk,
    output logic        par_req,
    output logic        par_wr,
    output logic [15:0] par_addr,
    output logic [15:0] par_wdata
);
    // ====================
    // Link idles with no request at time zero.
    initial begin
        par_req = 1'b0;
        par_wr = 1'b0;
        par_addr = 16'h0000;
        par_wdata = 16'h0000;
    end
    // One access, entered just after an edge; calls may run back to back.
    // References reach the drive only through this path.
    task automatic access(input logic w, input logic [15:0] a,
                          input logic [15:0] d);
        par_req <= 1'b1;
        par_wr <= w;
        par_addr <= a;
        par_wdata <= d;
        @(posedge sys_clk);
    endtask
    // Idle cycle: the released lines toggle so stale values never match.
    task automatic release_link();
        par_req <= 1'b0;
        par_wr <= ~par_wr;
        par_addr <= ~par_addr;
        par_wdata <= ~par_wdata;
        @(posedge sys_clk);
    endtask
endmodule // scvb_host_model

// ### dv/servo_comm_variable_bank_test.sv
// Self-checking bench for the servo communication variable bank.
`timescale 1ns/1ps
`define CHK(nm, e, g) begin compares++; if ((g) !== (e)) begin \
    mismatches++; $display("BAD %s exp %h got %h", nm, e, g); end end
module servo_comm_variable_bank_test;
    logic sys_clk, srst = 1'b1, par_req, par_wr, par_ack_r, par_err_r;
    logic bus_ready = 0, servo_on = 0, fault_class12 = 0, brake_assigned = 0;
    logic pos_source_pulse = 0, handwheel_active = 0, pulse_pin = 0;
    logic speed_mode_comm = 0, torque_mode_comm = 0, pulse_en = 0;
    logic speed_cmd_valid_r, torque_cmd_valid_r, period_tick_r;
    logic [15:0] par_addr, par_wdata, par_rdata_r, d;
    logic [15:0] virtual_input_r, out_level_r;
    logic [19:0] out_func_active = 20'h00000, f;
    logic [31:0] speed_cmd_r, torque_cmd_r;
    logic [17:0] expq[$];  // Pending answers: {check data, err, data}.
    logic [17:0] n;
    logic [3:0]  pcnt = 4'h0;
    logic [31:0] tv[7] = '{32'h005b8d80, 32'h005b8d81, 32'hffa47280,
        32'hffa4727f, 32'h000186a0, 32'h000186a1, 32'hfffe795f};
    int mismatches = 0, compares = 0, i;

    // ====================
    // Design with a short control period so counts settle quickly.
    scvb_var_bank #(.CTRL_PERIOD_CYC(20)) i_dut (
        .sys_clk(sys_clk), .srst(srst), .par_req(par_req), .par_wr(par_wr),
        .par_addr(par_addr), .par_wdata(par_wdata), .par_rdata_r(par_rdata_r),
        .par_ack_r(par_ack_r), .par_err_r(par_err_r), .bus_ready(bus_ready),
        .servo_on(servo_on), .fault_class12(fault_class12),
        .out_func_active(out_func_active), .brake_assigned(brake_assigned),
        .pos_source_pulse(pos_source_pulse), .pulse_pin(pulse_pin),
        .handwheel_active(handwheel_active), .speed_mode_comm(speed_mode_comm),
        .torque_mode_comm(torque_mode_comm), .virtual_input_r(virtual_input_r),
        .out_level_r(out_level_r), .speed_cmd_r(speed_cmd_r),
        .speed_cmd_valid_r(speed_cmd_valid_r), .torque_cmd_r(torque_cmd_r),
        .torque_cmd_valid_r(torque_cmd_valid_r),
        .period_tick_r(period_tick_r));
    scvb_host_model host (.sys_clk(sys_clk), .par_req(par_req),
        .par_wr(par_wr), .par_addr(par_addr), .par_wdata(par_wdata));

    // Clock at 25 MHz.
    initial begin
        sys_clk = 1'b0;
        forever #20 sys_clk = ~sys_clk;
    end
    // Pulse source: one rising edge every four cycles, five per period.
    always @(posedge sys_clk) begin
        pcnt <= pcnt + 4'h1;
        pulse_pin <= pulse_en & pcnt[1];
    end
    // Monitor: every answer retires the oldest noted expectation.
    always @(posedge sys_clk) begin
        if (par_ack_r === 1'b1) begin
            `CHK("noted", 1'b1, expq.size() > 0)
            if (expq.size() > 0) begin
                n = expq.pop_front();
                if (n[17]) `CHK("rdata", n[15:0], par_rdata_r)
                `CHK("err", n[16], par_err_r)
            end
        end
    end
    // Read and write helpers note the expected answer first.
    task automatic rd(input logic [15:0] a, input logic [15:0] e);
        expq.push_back({2'b10, e});
        host.access(1'b0, a, 16'h0000);
    endtask
    task automatic wr(input logic [15:0] a, input logic [15:0] v);
        expq.push_back(18'h00000);
        host.access(1'b1, a, v);
    endtask
    function automatic logic [31:0] clamp(input logic [31:0] v, input int l);
        if ($signed(v) > l) return l;
        if ($signed(v) < -l) return -l;
        return v;
    endfunction
    // Prints the counts and the verdict, then stops.
    task automatic tally_and_finish();
        $display("compares %0d mismatches %0d", compares, mismatches);
        if (mismatches == 0 && compares > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    // Watchdog well beyond the expected run of under a thousand cycles.
    initial begin
        #200000;
        mismatches++;
        tally_and_finish();
    end

    // ====================
    // Test sequence.
    initial begin
        void'($urandom(32'he4f4da86));
        repeat (8) @(posedge sys_clk);
        srst <= 1'b0;
        `CHK("spd_rst", 32'h0, speed_cmd_r)
        rd(16'h3109, 16'h0000);
        rd(16'h310c, 16'h0000);
        $display("test reset done");
        for (i = 0; i < 8; i++) begin
            {fault_class12, servo_on, bus_ready} <= i[2:0];
            host.release_link();
            rd(16'h3000, {2'b00, i[2] ? 2'h3 : (i[1] & i[0]) ? 2'h2 :
                {1'b0, i[0]}, 11'h000, i[0]});
        end
        wr(16'h3000, 16'hffff);
        rd(16'h3000, 16'h3001);
        $display("test status done");
        for (i = 0; i < 4; i++) begin
            f = 20'($urandom);
            out_func_active <= f;
            brake_assigned <= i[0];
            host.release_link();
            rd(16'h3001, {f[15:9], f[8] & i[0], f[7:0]});
            rd(16'h3002, {12'h000, f[19:16]});
        end
        $display("test output functions done");
        d = 16'($urandom);
        wr(16'h3100, d);
        wr(16'h3104, ~d);
        expq.push_back({2'b11, 16'h0000});
        host.access(1'b0, 16'h3105, 16'h0000);
        rd(16'h3100, d);
        `CHK("vin", d, virtual_input_r)
        `CHK("out", ~d, out_level_r)
        $display("test levels done");
        foreach (tv[k]) begin
            speed_mode_comm <= k[0];
            torque_mode_comm <= ~k[0];
            wr(16'h3109, tv[k][15:0]);
            wr(16'h310a, tv[k][31:16]);
            wr(16'h310b, tv[k][15:0]);
            wr(16'h310c, tv[k][31:16]);
            host.release_link();
            host.release_link();
            `CHK("spd", clamp(tv[k], 6000000), speed_cmd_r)
            `CHK("trq", clamp(tv[k], 100000), torque_cmd_r)
            `CHK("svld", k[0], speed_cmd_valid_r)
            `CHK("tvld", ~k[0], torque_cmd_valid_r)
        end
        $display("test references done");
        pos_source_pulse <= 1'b1;
        pulse_en <= 1'b1;
        repeat (60) host.release_link();
        rd(16'h3003, 16'h0005);
        pos_source_pulse <= 1'b0;
        handwheel_active <= 1'b1;
        servo_on <= 1'b0;
        repeat (60) host.release_link();
        rd(16'h3003, 16'h0005);
        handwheel_active <= 1'b0;
        repeat (2) host.release_link();
        rd(16'h3003, 16'h0000);
        repeat (3) host.release_link();
        `CHK("queue", 0, expq.size())
        $display("test pulse count done");
        srst <= 1'b1;
        repeat (2) host.release_link();
        srst <= 1'b0;
        rd(16'h310a, 16'h0000);
        rd(16'h310c, 16'h0000);
        repeat (3) host.release_link();
        `CHK("spd_rst2", 32'h0, speed_cmd_r)
        `CHK("queue2", 0, expq.size())
        $display("test mid-run reset done");
        tally_and_finish();
    end
endmodule // servo_comm_variable_bank_test
